// ===== logic/paof_top.sv
// Port pin mux with alternate-function overrides and port registers
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module paof_top
	import paof_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register port
	input wire logic [paof_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [paof_pkg::PORT_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [paof_pkg::PORT_W-1:0] reg_rdata,
	// Power control: disables digital input buffers unless overridden
	input wire logic input_buf_sleep,
	// External memory interface
	input wire logic ext_mem_enable,
	input wire logic mem_read_strobe,
	input wire logic mem_write_strobe,
	input wire logic addr_latch_enable,
	// Serial port
	input wire logic transmitter_on,
	input wire logic tx_data,
	input wire logic receiver_on,
	input wire logic serial_clock_out_en,
	input wire logic serial_clock_out,
	output logic rx_data_in,
	output logic serial_clock_in,
	// Timer1
	input wire logic timer1_compare_a_en,
	input wire logic timer1_compare_a_out,
	input wire logic timer1_compare_b_en,
	input wire logic timer1_compare_b_out,
	output logic timer1_capture_in,
	// External interrupts
	input wire logic ext_irq_zero_en,
	input wire logic ext_irq_one_en,
	input wire logic ext_irq_two_en,
	output logic ext_irq_zero_in,
	output logic ext_irq_one_in,
	output logic ext_irq_two_in,
	// Port A pins
	input wire logic [paof_pkg::PORT_W-1:0] pa_pin,
	output logic [paof_pkg::PORT_W-1:0] pa_oe,
	output logic [paof_pkg::PORT_W-1:0] pa_out,
	output logic [paof_pkg::PORT_W-1:0] pa_pullup,
	// Port B pins
	input wire logic [paof_pkg::PORT_W-1:0] pb_pin,
	output logic [paof_pkg::PORT_W-1:0] pb_oe,
	output logic [paof_pkg::PORT_W-1:0] pb_out,
	output logic [paof_pkg::PORT_W-1:0] pb_pullup,
	// Port C pins
	input wire logic [paof_pkg::PORT_W-1:0] pc_pin,
	output logic [paof_pkg::PORT_W-1:0] pc_oe,
	output logic [paof_pkg::PORT_W-1:0] pc_out,
	output logic [paof_pkg::PORT_W-1:0] pc_pullup,
	// Port D pins
	input wire logic [paof_pkg::PORT_W-1:0] pd_pin,
	output logic [paof_pkg::PORT_W-1:0] pd_oe,
	output logic [paof_pkg::PORT_W-1:0] pd_out,
	output logic [paof_pkg::PORT_W-1:0] pd_pullup,
	// Port E pins
	input wire logic [paof_pkg::PE_W-1:0] pe_pin,
	output logic [paof_pkg::PE_W-1:0] pe_oe,
	output logic [paof_pkg::PE_W-1:0] pe_out,
	output logic [paof_pkg::PE_W-1:0] pe_pullup
);
	import paof_pkg::*;

	// ----------------------------------------
	// Address decode helpers
	// ----------------------------------------

	// Kind of register at an address
	function automatic paof_kind_e dec_kind(input logic [ADDR_W-1:0] a);
		paof_kind_e k;
		if (a == OFS_PA_LATCH || a == OFS_PB_LATCH || a == OFS_PC_LATCH
			|| a == OFS_PD_LATCH || a == OFS_PE_LATCH)
			k = KIND_LATCH;
		else if (a == OFS_PA_DIR || a == OFS_PB_DIR || a == OFS_PC_DIR
			|| a == OFS_PD_DIR || a == OFS_PE_DIR)
			k = KIND_DIR;
		else if (a == OFS_PA_PINS || a == OFS_PB_PINS || a == OFS_PC_PINS
			|| a == OFS_PD_PINS || a == OFS_PE_PINS)
			k = KIND_PINS;
		else if (a == OFS_CTRL)
			k = KIND_CTRL;
		else
			k = KIND_NONE;
		return k;
	endfunction

	// Port index of an address, meaningful only for port registers
	function automatic logic [PIDX_W-1:0] dec_port(input logic [ADDR_W-1:0] a);
		logic [PIDX_W-1:0] p;
		if (a == OFS_PA_LATCH || a == OFS_PA_DIR || a == OFS_PA_PINS)
			p = 3'h0;
		else if (a == OFS_PB_LATCH || a == OFS_PB_DIR || a == OFS_PB_PINS)
			p = 3'h1;
		else if (a == OFS_PC_LATCH || a == OFS_PC_DIR || a == OFS_PC_PINS)
			p = 3'h2;
		else if (a == OFS_PD_LATCH || a == OFS_PD_DIR || a == OFS_PD_PINS)
			p = 3'h3;
		else
			p = 3'h4;
		return p;
	endfunction

	// Implemented bits of a port; port E has only three pins
	function automatic logic [PORT_W-1:0] port_mask(input logic [PIDX_W-1:0] p);
		return (p == 3'h4) ? PE_MASK : FULL_MASK;
	endfunction

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [PORT_W-1:0] latch_q [NUM_PORTS];
	logic [PORT_W-1:0] dir_q [NUM_PORTS];
	logic [PORT_W-1:0] ctrl_q;
	logic [NUM_PINS-1:0] din_q;
	logic [PORT_W-1:0] rdata_q;
	logic [NUM_PINS-1:0] oe_q;
	logic [NUM_PINS-1:0] out_q;
	logic [NUM_PINS-1:0] pu_q;

	paof_kind_e acc_kind;
	logic [PIDX_W-1:0] acc_port;
	logic global_pullup_disable;

	assign acc_kind = dec_kind(reg_addr);
	assign acc_port = dec_port(reg_addr);
	assign global_pullup_disable = ctrl_q[CTRL_PUD_BIT];

	// Output latches; unused port E bits stay zero
	always_ff @(posedge clock)
	begin
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			if (sys_rst)
				latch_q[p] <= RST_LATCH;
			else if (reg_wr && acc_kind == KIND_LATCH && acc_port == PIDX_W'(p))
				latch_q[p] <= reg_wdata & port_mask(PIDX_W'(p));
		end
	end

	// Direction registers; zero after reset leaves every pin an input
	always_ff @(posedge clock)
	begin
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			if (sys_rst)
				dir_q[p] <= RST_DIR;
			else if (reg_wr && acc_kind == KIND_DIR && acc_port == PIDX_W'(p))
				dir_q[p] <= reg_wdata & port_mask(PIDX_W'(p));
		end
	end

	// Control register holding the global pull-up disable
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			ctrl_q <= RST_CTRL;
		else if (reg_wr && acc_kind == KIND_CTRL)
			ctrl_q <= reg_wdata & (PORT_W'(1) << CTRL_PUD_BIT);
	end

	// ----------------------------------------
	// Flat per-pin views
	// ----------------------------------------
	logic [NUM_PINS-1:0] latch_flat;
	logic [NUM_PINS-1:0] dir_flat;
	logic [NUM_PINS-1:0] pin_flat;

	always_comb
	begin
		for (int i = 0; i < NUM_PINS; i++)
		begin
			latch_flat[i] = latch_q[i / PORT_W][i % PORT_W];
			dir_flat[i] = dir_q[i / PORT_W][i % PORT_W];
		end
	end

	assign pin_flat = {pe_pin, pd_pin, pc_pin, pb_pin, pa_pin};

	// ----------------------------------------
	// Override sources for ports D and E
	// ----------------------------------------
	logic [NUM_PINS-1:0] pu_ov_en;
	logic [NUM_PINS-1:0] pu_ov_val;
	logic [NUM_PINS-1:0] dd_ov_en;
	logic [NUM_PINS-1:0] dd_ov_val;
	logic [NUM_PINS-1:0] pv_ov_en;
	logic [NUM_PINS-1:0] pv_ov_val;
	logic [NUM_PINS-1:0] ib_ov_en;
	logic [NUM_PINS-1:0] ib_ov_val;

	// Ports A to C carry no overrides here; every default is the register path
	always_comb
	begin
		pu_ov_en = '0;
		pu_ov_val = '0;
		dd_ov_en = '0;
		dd_ov_val = '0;
		pv_ov_en = '0;
		pv_ov_val = '0;
		ib_ov_en = '0;
		ib_ov_val = '0;
		// Memory read strobe on D7
		pu_ov_en[PD_BASE + PD_RDS] = ext_mem_enable;
		dd_ov_en[PD_BASE + PD_RDS] = ext_mem_enable;
		dd_ov_val[PD_BASE + PD_RDS] = 1'b1;
		pv_ov_en[PD_BASE + PD_RDS] = ext_mem_enable;
		pv_ov_val[PD_BASE + PD_RDS] = mem_read_strobe;
		// Memory write strobe on D6
		pu_ov_en[PD_BASE + PD_WRS] = ext_mem_enable;
		dd_ov_en[PD_BASE + PD_WRS] = ext_mem_enable;
		dd_ov_val[PD_BASE + PD_WRS] = 1'b1;
		pv_ov_en[PD_BASE + PD_WRS] = ext_mem_enable;
		pv_ov_val[PD_BASE + PD_WRS] = mem_write_strobe;
		// Value-only overrides; direction stays with software
		pv_ov_en[PD_BASE + PD_CMPA] = timer1_compare_a_en;
		pv_ov_val[PD_BASE + PD_CMPA] = timer1_compare_a_out;
		pv_ov_en[PD_BASE + PD_XCK] = serial_clock_out_en;
		pv_ov_val[PD_BASE + PD_XCK] = serial_clock_out;
		// Interrupt pins keep their buffers alive in sleep
		ib_ov_en[PD_BASE + PD_IRQ1] = ext_irq_one_en;
		ib_ov_val[PD_BASE + PD_IRQ1] = 1'b1;
		ib_ov_en[PD_BASE + PD_IRQ0] = ext_irq_zero_en;
		ib_ov_val[PD_BASE + PD_IRQ0] = 1'b1;
		// Transmit data on D1
		pu_ov_en[PD_BASE + PD_TXD] = transmitter_on;
		dd_ov_en[PD_BASE + PD_TXD] = transmitter_on;
		dd_ov_val[PD_BASE + PD_TXD] = 1'b1;
		pv_ov_en[PD_BASE + PD_TXD] = transmitter_on;
		pv_ov_val[PD_BASE + PD_TXD] = tx_data;
		// Receive on D0: forced input, pull-up still from the latch bit
		pu_ov_en[PD_BASE + PD_RXD] = receiver_on;
		pu_ov_val[PD_BASE + PD_RXD] = latch_flat[PD_BASE + PD_RXD] & ~global_pullup_disable;
		dd_ov_en[PD_BASE + PD_RXD] = receiver_on;
		dd_ov_val[PD_BASE + PD_RXD] = 1'b0;
		// Compare B on E2; the pin drives only once software sets its direction
		pv_ov_en[PE_BASE + PE_CMPB] = timer1_compare_b_en;
		pv_ov_val[PE_BASE + PE_CMPB] = timer1_compare_b_out;
		// Address latch enable on E1
		pu_ov_en[PE_BASE + PE_ALE] = ext_mem_enable;
		dd_ov_en[PE_BASE + PE_ALE] = ext_mem_enable;
		dd_ov_val[PE_BASE + PE_ALE] = 1'b1;
		pv_ov_en[PE_BASE + PE_ALE] = ext_mem_enable;
		pv_ov_val[PE_BASE + PE_ALE] = addr_latch_enable;
		// E0 buffer forced on for interrupt 2; capture shares it
		ib_ov_en[PE_BASE + PE_CAPT] = ext_irq_two_en;
		ib_ov_val[PE_BASE + PE_CAPT] = 1'b1;
	end

	// ----------------------------------------
	// Pin cells
	// ----------------------------------------
	logic [NUM_PINS-1:0] cell_oe;
	logic [NUM_PINS-1:0] cell_out;
	logic [NUM_PINS-1:0] cell_pu;
	logic [NUM_PINS-1:0] cell_din;

	for (genvar i = 0; i < NUM_PINS; i++)
	begin : g_pin
		paof_pin_cell u_cell
		(
			.reg_latch(latch_flat[i]),
			.reg_dir(dir_flat[i]),
			.global_pullup_disable(global_pullup_disable),
			.buf_sleep(input_buf_sleep),
			.pullup_override_en(pu_ov_en[i]),
			.pullup_override_val(pu_ov_val[i]),
			.direction_override_en(dd_ov_en[i]),
			.direction_override_val(dd_ov_val[i]),
			.outval_override_en(pv_ov_en[i]),
			.outval_override_val(pv_ov_val[i]),
			.input_buf_override_en(ib_ov_en[i]),
			.input_buf_override_val(ib_ov_val[i]),
			.pin_level(pin_flat[i]),
			.drive_en(cell_oe[i]),
			.drive_val(cell_out[i]),
			.pullup_en(cell_pu[i]),
			.din(cell_din[i])
		);
	end

	// Pin drive is registered: one cycle from any control change to the pad
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			oe_q <= '0;
			out_q <= '0;
			pu_q <= '0;
		end
		else
		begin
			oe_q <= cell_oe;
			out_q <= cell_out;
			pu_q <= cell_pu;
		end
	end

	// Sampled pin levels; the same flop feeds registers and peripherals
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			din_q <= RST_PINS;
		else
			din_q <= cell_din;
	end

	// ----------------------------------------
	// Register read: data valid the cycle after the strobe only
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			rdata_q <= RST_RDATA;
		else if (reg_rd)
		begin
			if (acc_kind == KIND_LATCH)
				rdata_q <= latch_q[acc_port];
			else if (acc_kind == KIND_DIR)
				rdata_q <= dir_q[acc_port];
			else if (acc_kind == KIND_PINS)
				rdata_q <= PORT_W'(din_q >> (acc_port * PORT_W)) & port_mask(acc_port);
			else if (acc_kind == KIND_CTRL)
				rdata_q <= ctrl_q;
			else
				rdata_q <= RST_RDATA;
		end
		else
			rdata_q <= RST_RDATA;
	end

	// ----------------------------------------
	// Outputs, all straight from flops
	// ----------------------------------------
	assign reg_rdata = rdata_q;
	assign rx_data_in = din_q[PD_BASE + PD_RXD];
	assign serial_clock_in = din_q[PD_BASE + PD_XCK];
	assign ext_irq_zero_in = din_q[PD_BASE + PD_IRQ0];
	assign ext_irq_one_in = din_q[PD_BASE + PD_IRQ1];
	assign ext_irq_two_in = din_q[PE_BASE + PE_CAPT];
	assign timer1_capture_in = din_q[PE_BASE + PE_CAPT];

	assign pa_oe = oe_q[7:0];
	assign pa_out = out_q[7:0];
	assign pa_pullup = pu_q[7:0];
	assign pb_oe = oe_q[15:8];
	assign pb_out = out_q[15:8];
	assign pb_pullup = pu_q[15:8];
	assign pc_oe = oe_q[23:16];
	assign pc_out = out_q[23:16];
	assign pc_pullup = pu_q[23:16];
	assign pd_oe = oe_q[31:24];
	assign pd_out = out_q[31:24];
	assign pd_pullup = pu_q[31:24];
	assign pe_oe = oe_q[34:32];
	assign pe_out = out_q[34:32];
	assign pe_pullup = pu_q[34:32];
endmodule

// ===== logic/paof_pkg.sv
// Package of constants for the port alternate-function override block
package paof_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int NUM_PORTS = 5;
	localparam int PORT_W = 8;
	localparam int PE_W = 3;
	localparam int NUM_PINS = 35;
	localparam int ADDR_W = 8;
	localparam int PIDX_W = 3;

	// Flat pin index of bit 0 of ports D and E
	localparam int PD_BASE = 24;
	localparam int PE_BASE = 32;

	// Alternate function bit positions
	localparam int PD_RXD = 0;
	localparam int PD_TXD = 1;
	localparam int PD_IRQ0 = 2;
	localparam int PD_IRQ1 = 3;
	localparam int PD_XCK = 4;
	localparam int PD_CMPA = 5;
	localparam int PD_WRS = 6;
	localparam int PD_RDS = 7;
	localparam int PE_CAPT = 0;
	localparam int PE_ALE = 1;
	localparam int PE_CMPB = 2;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_PA_LATCH = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_PA_DIR = 8'h01;
	localparam logic [ADDR_W-1:0] OFS_PA_PINS = 8'h02;
	localparam logic [ADDR_W-1:0] OFS_PB_LATCH = 8'h03;
	localparam logic [ADDR_W-1:0] OFS_PB_DIR = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_PB_PINS = 8'h05;
	localparam logic [ADDR_W-1:0] OFS_PC_LATCH = 8'h06;
	localparam logic [ADDR_W-1:0] OFS_PC_DIR = 8'h07;
	localparam logic [ADDR_W-1:0] OFS_PC_PINS = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_PD_LATCH = 8'h09;
	localparam logic [ADDR_W-1:0] OFS_PD_DIR = 8'h0A;
	localparam logic [ADDR_W-1:0] OFS_PD_PINS = 8'h0B;
	localparam logic [ADDR_W-1:0] OFS_PE_LATCH = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_PE_DIR = 8'h0D;
	localparam logic [ADDR_W-1:0] OFS_PE_PINS = 8'h0E;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h0F;

	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int CTRL_PUD_BIT = 0;
	localparam logic [PORT_W-1:0] PE_MASK = 8'h07;
	localparam logic [PORT_W-1:0] FULL_MASK = 8'hFF;
	localparam logic [PORT_W-1:0] RST_LATCH = 8'h00;
	localparam logic [PORT_W-1:0] RST_DIR = 8'h00;
	localparam logic [PORT_W-1:0] RST_CTRL = 8'h00;
	localparam logic [PORT_W-1:0] RST_RDATA = 8'h00;
	localparam logic [NUM_PINS-1:0] RST_PINS = 35'h0_0000_0000;

	// Register kind selected by an address
	typedef enum logic [2:0] {
		KIND_LATCH,
		KIND_DIR,
		KIND_PINS,
		KIND_CTRL,
		KIND_NONE
	} paof_kind_e;

endpackage

// ===== logic/paof_pin_cell.sv
// One pin: merges register settings with alternate-function overrides
`timescale 1ns/1ps
module paof_pin_cell
(
	// Register settings
	input wire logic reg_latch,
	input wire logic reg_dir,
	input wire logic global_pullup_disable,
	input wire logic buf_sleep,
	// Override pairs
	input wire logic pullup_override_en,
	input wire logic pullup_override_val,
	input wire logic direction_override_en,
	input wire logic direction_override_val,
	input wire logic outval_override_en,
	input wire logic outval_override_val,
	input wire logic input_buf_override_en,
	input wire logic input_buf_override_val,
	// Pin side
	input wire logic pin_level,
	output logic drive_en,
	output logic drive_val,
	output logic pullup_en,
	output logic din
);
	logic buf_on;

	// Each enabled override wins over the register path
	always_comb
	begin
		drive_en = direction_override_en ? direction_override_val : reg_dir;
		drive_val = outval_override_en ? outval_override_val : reg_latch;
		pullup_en = pullup_override_en ? pullup_override_val
			: (reg_latch & ~reg_dir & ~global_pullup_disable);
		buf_on = input_buf_override_en ? input_buf_override_val : ~buf_sleep;
		// A disabled buffer reads low so a floating pin cannot toggle logic
		din = buf_on & pin_level;
	end
endmodule

// ===== bench/paof_top_asserts.sv
// Checker of the port override behaviour seen at the block's ports
`timescale 1ns/1ps
module paof_top_asserts
(
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Peripheral side
	input wire logic input_buf_sleep,
	input wire logic ext_mem_enable,
	input wire logic mem_read_strobe,
	input wire logic mem_write_strobe,
	input wire logic addr_latch_enable,
	input wire logic transmitter_on,
	input wire logic tx_data,
	input wire logic receiver_on,
	input wire logic serial_clock_out_en,
	input wire logic serial_clock_out,
	input wire logic rx_data_in,
	input wire logic serial_clock_in,
	input wire logic timer1_compare_a_en,
	input wire logic timer1_compare_a_out,
	input wire logic timer1_compare_b_en,
	input wire logic timer1_compare_b_out,
	input wire logic timer1_capture_in,
	input wire logic ext_irq_zero_en,
	input wire logic ext_irq_one_en,
	input wire logic ext_irq_two_en,
	input wire logic ext_irq_zero_in,
	input wire logic ext_irq_one_in,
	input wire logic ext_irq_two_in,
	// Port D and E pins
	input wire logic [paof_pkg::PORT_W-1:0] pd_pin,
	input wire logic [paof_pkg::PORT_W-1:0] pd_oe,
	input wire logic [paof_pkg::PORT_W-1:0] pd_out,
	input wire logic [paof_pkg::PORT_W-1:0] pd_pullup,
	input wire logic [paof_pkg::PE_W-1:0] pe_pin,
	input wire logic [paof_pkg::PE_W-1:0] pe_oe,
	input wire logic [paof_pkg::PE_W-1:0] pe_out,
	input wire logic [paof_pkg::PE_W-1:0] pe_pullup
);
	import paof_pkg::*;

	// Every override reaches the pins one edge after it is sampled
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	rx_input_a: assert property (receiver_on |=> !pd_oe[0]) else $error("receive pin driven");
	rx_data_a: assert property (receiver_on && !input_buf_sleep |=> rx_data_in == $past(pd_pin[0]))
		else $error("receive data not from pin");
	mem_strobe_a: assert property (ext_mem_enable |=> pd_oe[7:6] == 2'h3 && pd_pullup[7:6] == 2'h0
		&& pd_out[7:6] == {$past(mem_read_strobe), $past(mem_write_strobe)}) else $error("strobe pins wrong");
	mem_latch_a: assert property (ext_mem_enable |=> pe_oe[1] && !pe_pullup[1]
		&& pe_out[1] == $past(addr_latch_enable)) else $error("latch enable pin wrong");
	tx_drive_a: assert property (transmitter_on |=> pd_oe[1] && !pd_pullup[1] && pd_out[1] == $past(tx_data))
		else $error("transmit pin wrong");
	cmp_a_a: assert property (timer1_compare_a_en |=> pd_out[5] == $past(timer1_compare_a_out))
		else $error("compare A value wrong");
	sclk_out_a: assert property (serial_clock_out_en |=> pd_out[4] == $past(serial_clock_out))
		else $error("serial clock value wrong");
	sclk_in_a: assert property (!input_buf_sleep |=> serial_clock_in == $past(pd_pin[4]))
		else $error("serial clock input wrong");
	cmp_b_a: assert property (timer1_compare_b_en |=> pe_out[2] == $past(timer1_compare_b_out))
		else $error("compare B value wrong");
	irq_zero_a: assert property (ext_irq_zero_en |=> ext_irq_zero_in == $past(pd_pin[2]))
		else $error("interrupt 0 input wrong");
	irq_one_a: assert property (ext_irq_one_en |=> ext_irq_one_in == $past(pd_pin[3]))
		else $error("interrupt 1 input wrong");
	capt_pin_a: assert property (ext_irq_two_en |=> timer1_capture_in == $past(pe_pin[0]))
		else $error("capture input wrong");
	capt_share_a: assert property (timer1_capture_in == ext_irq_two_in) else $error("E0 inputs differ");
endmodule

bind paof_top paof_top_asserts i_paof_top_asserts (.clock, .sys_rst, .input_buf_sleep, .ext_mem_enable,
	.mem_read_strobe, .mem_write_strobe, .addr_latch_enable, .transmitter_on, .tx_data, .receiver_on,
	.serial_clock_out_en, .serial_clock_out, .rx_data_in, .serial_clock_in, .timer1_compare_a_en,
	.timer1_compare_a_out, .timer1_compare_b_en, .timer1_compare_b_out, .timer1_capture_in, .ext_irq_zero_en,
	.ext_irq_one_en, .ext_irq_two_en, .ext_irq_zero_in, .ext_irq_one_in, .ext_irq_two_in, .pd_pin, .pd_oe,
	.pd_out, .pd_pullup, .pe_pin, .pe_oe, .pe_out, .pe_pullup);

// ===== bench/paof_board.sv
// Board model: resolves every pad from device drive, outside drivers and pull-ups
`timescale 1ns/1ps
module paof_board
(
	// Clock
	input wire logic clock,
	// Device side, all ports flattened
	input wire logic [paof_pkg::NUM_PINS-1:0] oe,
	input wire logic [paof_pkg::NUM_PINS-1:0] out,
	input wire logic [paof_pkg::NUM_PINS-1:0] pull_en,
	// Outside drivers on the board
	input wire logic [paof_pkg::NUM_PINS-1:0] ext_en,
	input wire logic [paof_pkg::NUM_PINS-1:0] ext_val,
	output logic [paof_pkg::NUM_PINS-1:0] pin
);
	import paof_pkg::*;

	logic [NUM_PINS-1:0] float_q = '0;

	// A pad nobody holds wanders each cycle, so a missing pull-up never reads as a steady level
	always_ff @(posedge clock)
		float_q <= ~float_q;

	// Device drive wins, then an outside driver, then pull-up, else the wandering level
	assign pin = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pull_en | float_q));
endmodule

// ===== bench/test_paof_top.sv
// Self-checking testbench of the port override block
`timescale 1ns/1ps
module test_paof_top;
	import paof_pkg::*;

	logic clock, sys_rst, reg_wr, reg_rd, input_buf_sleep, ext_mem_enable, mem_read_strobe, mem_write_strobe;
	logic addr_latch_enable, transmitter_on, tx_data, receiver_on, serial_clock_out_en, serial_clock_out;
	logic timer1_compare_a_en, timer1_compare_a_out, timer1_compare_b_en, timer1_compare_b_out;
	logic ext_irq_zero_en, ext_irq_one_en, ext_irq_two_en, rx_data_in, serial_clock_in, timer1_capture_in;
	logic ext_irq_zero_in, ext_irq_one_in, ext_irq_two_in;
	logic [ADDR_W-1:0] reg_addr;
	logic [PORT_W-1:0] reg_wdata, reg_rdata, pa_pin, pa_oe, pa_out, pa_pullup, pb_pin, pb_oe, pb_out, pb_pullup;
	logic [PORT_W-1:0] pc_pin, pc_oe, pc_out, pc_pullup, pd_pin, pd_oe, pd_out, pd_pullup;
	logic [PE_W-1:0] pe_pin, pe_oe, pe_out, pe_pullup;
	logic [NUM_PINS-1:0] ext_en, ext_val, pin;
	logic [PORT_W-1:0] vals [6] = '{8'hC3, 8'h0F, 8'h96, 8'hF0, 8'h3C, 8'hAA};
	int error_cnt, checks;

	assign {pe_pin, pd_pin, pc_pin, pb_pin, pa_pin} = pin;

	paof_top i_paof_top (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .input_buf_sleep,
		.ext_mem_enable, .mem_read_strobe, .mem_write_strobe, .addr_latch_enable, .transmitter_on, .tx_data,
		.receiver_on, .serial_clock_out_en, .serial_clock_out, .rx_data_in, .serial_clock_in, .timer1_compare_a_en,
		.timer1_compare_a_out, .timer1_compare_b_en, .timer1_compare_b_out, .timer1_capture_in, .ext_irq_zero_en,
		.ext_irq_one_en, .ext_irq_two_en, .ext_irq_zero_in, .ext_irq_one_in, .ext_irq_two_in, .pa_pin, .pa_oe,
		.pa_out, .pa_pullup, .pb_pin, .pb_oe, .pb_out, .pb_pullup, .pc_pin, .pc_oe, .pc_out, .pc_pullup, .pd_pin,
		.pd_oe, .pd_out, .pd_pullup, .pe_pin, .pe_oe, .pe_out, .pe_pullup);

	paof_board i_paof_board (.clock, .oe({pe_oe, pd_oe, pc_oe, pb_oe, pa_oe}),
		.out({pe_out, pd_out, pc_out, pb_out, pa_out}),
		.pull_en({pe_pullup, pd_pullup, pc_pullup, pb_pullup, pa_pullup}), .ext_en, .ext_val, .pin);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	always #25 clock = ~clock;

	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
			error_cnt++;
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clock);
		reg_wr <= 1'h0;
	endtask

	// Read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clock);
		reg_rd <= 1'h0;
		#1;
		chk(reg_rdata, exp);
	endtask

	// Pin path needs an edge for the override and one more for the pad to come back in
	task settle;
		repeat (4) @(posedge clock);
		#1;
	endtask

	task wrap_up;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		for (int i = 0; i < 3; i++)
		begin
			rd(OFS_PA_LATCH + 8'(3 * i), RST_LATCH);
			rd(OFS_PA_DIR + 8'(3 * i), RST_DIR);
		end
		chk(pa_oe | pb_oe | pc_oe | pd_oe, 8'h00);
		$display("t_reset done");
	endtask

	task t_regs;
		@(posedge clock);
		ext_en[7:0] <= 8'hFF;
		ext_val[7:0] <= 8'h5A;
		for (int i = 0; i < 6; i++)
			wr(8'(3 * (i / 2) + i % 2), vals[i]);
		wr(OFS_PA_PINS, 8'hFF);
		settle;
		chk(pa_oe, 8'h0F);
		chk(pa_out & 8'h0F, 8'h03);
		chk(pa_pullup, 8'hC0);
		chk(pb_oe, 8'hF0);
		chk(pc_oe, 8'hAA);
		chk(pb_out, 8'h96);
		chk(pc_out, 8'h3C);
		chk(pb_pullup, 8'h06);
		chk(pc_pullup, 8'h14);
		rd(OFS_PA_PINS, 8'h53);
		for (int i = 0; i < 6; i++)
			rd(8'(3 * (i / 2) + i % 2), vals[i]);
		rd(8'h20, 8'h00);
		$display("t_regs done");
	endtask

	task t_xmem;
		wr(OFS_PD_LATCH, 8'hFF);
		wr(OFS_PE_LATCH, 8'hFF);
		ext_mem_enable <= 1'h1;
		mem_read_strobe <= 1'h1;
		addr_latch_enable <= 1'h1;
		settle;
		chk(pd_oe, 8'hC0);
		chk(pd_pullup, 8'h3F);
		chk(8'({pd_out[7:6], pe_out[1], pe_oe[1], pe_pullup[1]}), 8'h16);
		@(posedge clock);
		{mem_read_strobe, mem_write_strobe, addr_latch_enable} <= 3'h2;
		settle;
		chk(8'({pd_out[7:6], pe_out[1]}), 8'h02);
		@(posedge clock);
		ext_mem_enable <= 1'h0;
		settle;
		chk(pd_oe | 8'(pe_oe), 8'h00);
		chk(pd_pullup, 8'hFF);
		rd(OFS_PE_LATCH, 8'h07);
		$display("t_xmem done");
	endtask

	task t_serial;
		wr(OFS_PD_DIR, 8'h31);
		{transmitter_on, receiver_on, serial_clock_out_en} <= 3'h7;
		ext_en[PD_BASE] <= 1'h1;
		ext_val[PD_BASE] <= 1'h1;
		settle;
		chk(pd_oe, 8'h32);
		chk(pd_pullup, 8'hCD);
		chk(8'({pd_out[1], pd_out[4], serial_clock_in, rx_data_in}), 8'h01);
		wr(OFS_CTRL, 8'hFF);
		{tx_data, serial_clock_out} <= 2'h3;
		ext_val[PD_BASE] <= 1'h0;
		settle;
		chk(pd_pullup, 8'h00);
		chk(8'({pd_out[1], pd_out[4], serial_clock_in, rx_data_in}), 8'h0E);
		rd(OFS_CTRL, 8'h01);
		wr(OFS_CTRL, 8'h00);
		{transmitter_on, receiver_on, serial_clock_out_en} <= 3'h0;
		$display("t_serial done");
	endtask

	task t_timer;
		wr(OFS_PE_DIR, 8'h04);
		{timer1_compare_a_en, timer1_compare_b_en} <= 2'h3;
		ext_en[PE_BASE] <= 1'h1;
		ext_val[PE_BASE] <= 1'h1;
		settle;
		chk(8'({pe_out[2], pe_oe[2], pd_out[5]}), 8'h02);
		chk(8'({timer1_capture_in, ext_irq_two_in, pe_oe[0], pe_pullup[0]}), 8'h0D);
		@(posedge clock);
		{timer1_compare_a_out, timer1_compare_b_out} <= 2'h3;
		ext_val[PE_BASE] <= 1'h0;
		settle;
		chk(8'({pe_out[2], pd_out[5], timer1_capture_in, ext_irq_two_in}), 8'h0C);
		$display("t_timer done");
	endtask

	task t_irq;
		@(posedge clock);
		input_buf_sleep <= 1'h1;
		ext_en[PD_BASE + 3 -: 2] <= 2'h3;
		ext_val[PD_BASE + 3 -: 2] <= 2'h3;
		ext_val[PE_BASE] <= 1'h1;
		settle;
		chk(8'({ext_irq_two_in, ext_irq_one_in, ext_irq_zero_in}), 8'h00);
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clock);
			{ext_irq_two_en, ext_irq_one_en, ext_irq_zero_en} <= 3'(1 << i);
			settle;
			chk(8'({ext_irq_two_in, ext_irq_one_in, ext_irq_zero_in}), 8'(1 << i));
		end
		$display("t_irq done");
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		clock = 1'h0;
		sys_rst = 1'h1;
		{reg_wr, reg_rd, input_buf_sleep, ext_mem_enable, mem_read_strobe, mem_write_strobe} = '0;
		{addr_latch_enable, transmitter_on, tx_data, receiver_on, serial_clock_out_en, serial_clock_out} = '0;
		{timer1_compare_a_en, timer1_compare_a_out, timer1_compare_b_en, timer1_compare_b_out} = '0;
		{ext_irq_zero_en, ext_irq_one_en, ext_irq_two_en, reg_addr, reg_wdata, ext_en, ext_val} = '0;
		repeat (4) @(posedge clock);
		sys_rst <= 1'h0;
		t_reset;
		t_regs;
		t_xmem;
		t_serial;
		t_timer;
		t_irq;
		wrap_up;
	end

	// A hang counts as a mismatch
	initial
	begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		wrap_up;
	end
endmodule
